// File: mif_consts.vh
/*
 * Constants for the meter interrupt flag block: register addresses,
 * flag bit positions and mode field positions.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef MIF_CONSTS_VH
`define MIF_CONSTS_VH

// ==========================================================
// Register addresses
`define MIF_ADDR_ENABLE      8'h0A
`define MIF_ADDR_STATUS      8'h0B
`define MIF_ADDR_STATUS_CLR  8'h0C

// ==========================================================
// Flag bit positions
`define MIF_BIT_EHALF  0
`define MIF_BIT_DIP    1
`define MIF_BIT_CYC    2
`define MIF_BIT_WAVE   3
`define MIF_BIT_ZCROSS 4
`define MIF_BIT_TEMP   5
`define MIF_BIT_RST    6
`define MIF_NFLAGS     7

// ==========================================================
// Mode field positions and reset values
`define MIF_WSRC_LSB    13
`define MIF_WSRC_MSB    14
`define MIF_POSONLY_BIT 15
`define MIF_ENABLE_RST  16'h0000
`define MIF_MODE_RST    3'h0

// ==========================================================
// Waveform source codes
`define MIF_SRC_POWER   2'h0
`define MIF_SRC_RSVD    2'h1
`define MIF_SRC_CURR    2'h2
`define MIF_SRC_VOLT    2'h3

`endif

// File: mif_wave_mux.v
/*
 * Waveform sample source selector and positive-only power gate.
 * Assumes samples are already aligned to 24 bits and synchronous to clk.
 */
`timescale 1ns/1ps
`include "mif_consts.vh"

module mif_wave_mux #(
    parameter W = 24
) (
    input  wire         clk,           // System clock
    input  wire         rstn,          // Synchronous reset, active low
    input  wire [1:0]   wave_sel,      // Waveform source select
    input  wire         pos_only,      // Positive-only accumulate
    input  wire [W-1:0] power_in,      // Filtered active power
    input  wire [W-1:0] curr_in,       // Current channel sample
    input  wire [W-1:0] volt_in,       // Voltage channel sample
    output reg  [W-1:0] wave_r,        // Selected waveform sample
    output reg  [W-1:0] accum_pwr_r    // Power toward accumulation
);

    // ==========================================================
    // Source selection
    always @(posedge clk) begin
        if (!rstn) begin
            wave_r <= {W{1'b0}};
        end else begin
            case (wave_sel)
                `MIF_SRC_POWER: wave_r <= power_in;
                `MIF_SRC_CURR:  wave_r <= curr_in;
                `MIF_SRC_VOLT:  wave_r <= volt_in;
                default:        wave_r <= {W{1'b0}}; // Reserved code reads zero
            endcase
        end
    end

    // ==========================================================
    // Negative power dropped when positive-only is set
    always @(posedge clk) begin
        if (!rstn) begin
            accum_pwr_r <= {W{1'b0}};
        end else if (pos_only && power_in[W-1]) begin
            accum_pwr_r <= {W{1'b0}};
        end else begin
            accum_pwr_r <= power_in;
        end
    end

endmodule // mif_wave_mux

// File: mif_irq_flags.v
/*
 * Interrupt flag, enable and request logic of the metering device,
 * with waveform source select and positive-only accumulate mode bits.
 * Assumes a register port (address, read/write strobes) decoded from
 * the serial interface, and metering event pulses synchronous to clk.
 */
// Overview of operation
// - A two-bit field picks the waveform source: power, reserved, current or voltage.
// - With positive-only set, only positive power reaches the energy accumulation; it resets to zero.
// - Each internal event other than zero-cross sets its matching sticky status flag.
// - The request output is low while any set flag other than reset-done has its enable bit set.
// - The half-full flag sets on a zero-to-one change of the energy accumulator's top bit.
// - The dip flag sets on a voltage sag or on missing zero crossings.
// - The cycle-done flag sets when accumulation over the half-cycle count completes.
// - The waveform sample flag sets each time a new sample is loaded.
// - The zero-cross status bit follows the zero-crossing logic output.
// - The temperature flag sets when a new conversion result is written.
// - The reset-done flag sets after any reset and never drives the request.
`timescale 1ns/1ps
`include "mif_consts.vh"

module mif_irq_flags #(
    parameter W = 24
) (
    input  wire         clk,              // 20 MHz system clock
    input  wire         rstn,             // Synchronous reset, active low
    input  wire         sw_reset,         // Software reset pulse
    input  wire [7:0]   reg_addr,         // Register address
    input  wire         reg_wr,           // Write strobe
    input  wire         reg_rd,           // Read strobe
    input  wire [15:0]  reg_wdata,        // Write data
    output reg  [15:0]  reg_rdata_r,      // Read data
    input  wire [W-1:0] active_energy_accum, // Energy accumulator value
    input  wire         sag_event,        // Voltage sag detected
    input  wire         zc_timeout,       // Missing zero crossings
    input  wire         line_cycle_done,  // Half-cycle count reached
    input  wire         zero_cross_in,    // Zero-crossing logic output
    input  wire         temp_written,     // Temperature result written
    input  wire [W-1:0] power_lowpass_output, // Filtered active power
    input  wire [W-1:0] curr_sample,      // Current channel sample
    input  wire [W-1:0] volt_sample,      // Voltage channel sample
    input  wire         wave_strobe,      // Waveform update tick
    input  wire [2:0]   mode_wdata,       // Mode bits 15..13 to load
    input  wire         mode_wr,          // Mode bits write strobe
    output wire [1:0]   waveform_source_select, // Current source code
    output wire         positive_only_accumulate, // Mode bit state
    output wire [W-1:0] waveform_data,    // Waveform register
    output wire [W-1:0] accum_power,      // Power into accumulation
    output wire         irq_n,            // Interrupt request, active low
    output wire         irq_oe            // Open-drain enable
);

    reg  [15:0]             irq_enable_mask_r;
    reg  [`MIF_NFLAGS-1:0]  flags_r;
    reg  [`MIF_NFLAGS-1:0]  flags_nxt;
    reg  [2:0]              mode_r;
    reg                     ae_msb_r;
    reg                     wave_load_r;
    reg                     rst_done_r;
    wire [`MIF_NFLAGS-1:0]  events;
    wire [`MIF_NFLAGS-1:0]  clr_mask;
    wire                    rd_clr;
    wire                    irq_active;
    wire                    sel_enable;
    wire                    sel_status;
    wire                    sel_clear;

    // ==========================================================
    // Address decoding, shared by the write and read paths
    function hit_addr;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit_addr = (addr == target);
        end
    endfunction

    // Status and clearing addresses return the same word
    assign sel_enable = hit_addr(reg_addr, `MIF_ADDR_ENABLE);
    assign sel_status = hit_addr(reg_addr, `MIF_ADDR_STATUS);
    assign sel_clear  = hit_addr(reg_addr, `MIF_ADDR_STATUS_CLR);

    // ==========================================================
    // Mode bits
    always @(posedge clk) begin
        if (!rstn || sw_reset) begin
            mode_r <= `MIF_MODE_RST;
        end else if (mode_wr) begin
            mode_r <= mode_wdata;
        end
    end

    assign waveform_source_select   = mode_r[1:0];
    assign positive_only_accumulate = mode_r[2];

    mif_wave_mux #(.W(W)) u_wave (
        .clk         (clk),
        .rstn        (rstn),
        .wave_sel    (waveform_source_select),
        .pos_only    (positive_only_accumulate),
        .power_in    (power_lowpass_output),
        .curr_in     (curr_sample),
        .volt_in     (volt_sample),
        .wave_r      (waveform_data),
        .accum_pwr_r (accum_power)
    );

    // ==========================================================
    // Event detection
    always @(posedge clk) begin
        if (!rstn || sw_reset) begin
            ae_msb_r    <= 1'b0;
            wave_load_r <= 1'b0;
            rst_done_r  <= 1'b1;
        end else begin
            ae_msb_r    <= active_energy_accum[W-1];
            wave_load_r <= wave_strobe;
            rst_done_r  <= 1'b0;
        end
    end

    // Wave flag lags strobe one cycle so it marks the loaded sample
    assign events[`MIF_BIT_EHALF]  = active_energy_accum[W-1] && !ae_msb_r;
    assign events[`MIF_BIT_DIP]    = sag_event || zc_timeout;
    assign events[`MIF_BIT_CYC]    = line_cycle_done;
    assign events[`MIF_BIT_WAVE]   = wave_load_r;
    // Zero-cross bit is live state, overridden below
    assign events[`MIF_BIT_ZCROSS] = 1'b0;
    assign events[`MIF_BIT_TEMP] = temp_written;
    assign events[`MIF_BIT_RST]  = rst_done_r;

    // ==========================================================
    // Status flags
    assign rd_clr   = reg_rd && sel_clear;
    assign clr_mask = rd_clr ? flags_r : {`MIF_NFLAGS{1'b0}};

    always @* begin
        flags_nxt = (flags_r & ~clr_mask) | events;
        flags_nxt[`MIF_BIT_ZCROSS] = zero_cross_in;
    end

    always @(posedge clk) begin
        if (!rstn || sw_reset) begin
            flags_r <= {`MIF_NFLAGS{1'b0}};
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ==========================================================
    // Enable register and read port
    always @(posedge clk) begin
        if (!rstn || sw_reset) begin
            irq_enable_mask_r <= `MIF_ENABLE_RST;
        end else if (reg_wr && sel_enable) begin
            irq_enable_mask_r <= reg_wdata;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            reg_rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            if (sel_enable) begin
                reg_rdata_r <= irq_enable_mask_r;
            end else if (sel_status || sel_clear) begin
                reg_rdata_r <= {{(16-`MIF_NFLAGS){1'b0}}, flags_r};
            end else begin
                reg_rdata_r <= 16'h0000;
            end
        end
    end

    // ==========================================================
    // Request output; reset-done bit excluded from the enable gate
    assign irq_active = |(flags_r[`MIF_BIT_RST-1:0]
                          & irq_enable_mask_r[`MIF_BIT_RST-1:0]);
    assign irq_n  = ~irq_active;
    assign irq_oe = irq_active;

endmodule // mif_irq_flags

// File: mif_irq_props.sv
/* Concurrent checks on the ports of mif_irq_flags.
   Assumes binding to the design top, one clock, sync reset. */
`timescale 1ns/1ps
module mif_irq_props #(parameter W = 24) (
    input wire         clk,                      // Clock
    input wire         rstn,                     // Reset, low
    input wire         sw_reset,                 // Soft reset
    input wire [7:0]   reg_addr,                 // Address
    input wire         reg_wr,                   // Write
    input wire         reg_rd,                   // Read
    input wire [15:0]  reg_rdata_r,              // Read data
    input wire [2:0]   mode_wdata,               // Mode data
    input wire         mode_wr,                  // Mode write
    input wire [1:0]   waveform_source_select,   // Source
    input wire         positive_only_accumulate, // Mode bit
    input wire         wave_strobe,              // Sample tick
    input wire [W-1:0] power_lowpass_output,     // Power
    input wire [W-1:0] curr_sample,              // Current
    input wire [W-1:0] volt_sample,              // Voltage
    input wire [W-1:0] waveform_data,            // Waveform
    input wire [W-1:0] accum_power,              // Accum power
    input wire         zero_cross_in,            // Zero cross
    input wire         irq_n,                    // Request
    input wire         irq_oe                    // Enable
);
    // ==========================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    reg [W-1:0] wexp_r;
    reg [W-1:0] aexp_r;
    wire [1:0] s = waveform_source_select;
    always @(posedge clk) begin
        wexp_r <= s == 2'h3 ? volt_sample : s == 2'h2 ? curr_sample : s == 2'h0 ? power_lowpass_output : {W{1'b0}};
        aexp_r <= positive_only_accumulate && power_lowpass_output[W-1] ? {W{1'b0}} : power_lowpass_output;
    end
    property p_oe; irq_oe == !irq_n; endproperty
    a_oe: assert property (p_oe) else $error("irq_oe not inverse of irq_n");
    property p_rst; $rose(rstn) |-> irq_n && s == 2'h0 && !positive_only_accumulate; endproperty
    a_rst: assert property (p_rst) else $error("state after reset wrong");
    property p_mode; mode_wr && !sw_reset |=> {positive_only_accumulate, s} == $past(mode_wdata); endproperty
    a_mode: assert property (p_mode) else $error("mode load wrong");
    property p_hold; !mode_wr && !sw_reset |=> $stable({positive_only_accumulate, s}); endproperty
    a_hold: assert property (p_hold) else $error("mode changed");
    property p_wave; wave_strobe && !sw_reset |=> waveform_data == wexp_r; endproperty
    a_wave: assert property (p_wave) else $error("waveform source wrong");
    property p_acc; !sw_reset |=> accum_power == aexp_r; endproperty
    a_acc: assert property (p_acc) else $error("accumulated power wrong");
    property p_zc; reg_rd && reg_addr == 8'h0B |=> reg_rdata_r[4] == $past(zero_cross_in, 2); endproperty
    a_zc: assert property (p_zc) else $error("zero cross bit wrong");
    property p_stand; !reg_rd |=> $stable(reg_rdata_r); endproperty
    a_stand: assert property (p_stand) else $error("read data moved");
    property p_irq; !irq_n && zero_cross_in && !reg_rd && !reg_wr && !sw_reset |=> !irq_n; endproperty
    a_irq: assert property (p_irq) else $error("request dropped");
    c_irq: cover property ($fell(irq_n));
    c_clr: cover property (reg_rd && reg_addr == 8'h0C ##1 irq_n);
    c_mode: cover property (mode_wr ##1 wave_strobe);
endmodule // mif_irq_props
bind mif_irq_flags mif_irq_props #(.W(W)) u_props (.*);

// File: mif_host_model.sv
/* Host model: register master that services requests.
   Assumes read data one cycle after the read strobe. */
`timescale 1ns/1ps
module mif_host_model (
    input  wire         clk,             // Clock
    input  wire         irq_n,           // Request, low
    input  wire  [15:0] reg_rdata_r,     // Read data
    output logic [7:0]  reg_addr = 0,    // Address
    output logic        reg_wr = 0,      // Write
    output logic        reg_rd = 0,      // Read
    output logic [15:0] reg_wdata = 0    // Write data
);
    // ==========================================
    // Bus tasks; idle lines show inverted data
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {~a, ~v, 1'b0};
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) {reg_addr, reg_rd} <= {~a, 1'b0};
        #1 v = reg_rdata_r;
    endtask
    task service(output logic [15:0] v);
        logic [15:0] t;
        for (int i = 0; i < 20 && irq_n !== 1'b0; i++) @(posedge clk);
        rd(8'h0B, v);
        rd(8'h0C, t);
    endtask
endmodule // mif_host_model

// File: tb_mif_irq_flags.sv
/* Self-checking bench for mif_irq_flags.
   Assumes the host model owns the register port. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_mif_irq_flags;
    localparam W = 24;
    logic clk = 0, rstn = 0, sw_reset = 0, sag_event = 0, zc_timeout = 0, line_cycle_done = 0;
    logic zero_cross_in = 0, temp_written = 0, wave_strobe = 0, mode_wr = 0;
    logic [2:0] mode_wdata = 0;
    logic [W-1:0] active_energy_accum = 0, power_lowpass_output = 0, curr_sample = 0, volt_sample = 0;
    wire [7:0] reg_addr;
    wire reg_wr, reg_rd, positive_only_accumulate, irq_n, irq_oe;
    wire [15:0] reg_wdata, reg_rdata_r;
    wire [1:0] waveform_source_select;
    wire [W-1:0] waveform_data, accum_power;
    logic [15:0] d;
    int mismatches = 0, total_checks = 0, cyc = 0;
    mif_irq_flags #(.W(W)) DUT (.*);
    mif_host_model u_host (.*);
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task summarize;
        if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task ev(input int i);
        @(posedge clk);
        case (i) 0: active_energy_accum[W-1] <= 1; 1: sag_event <= 1; 2: line_cycle_done <= 1;
            3: wave_strobe <= 1; 5: temp_written <= 1; default: zc_timeout <= 1; endcase
        @(posedge clk) {active_energy_accum[W-1], sag_event, line_cycle_done, wave_strobe, temp_written, zc_timeout} <= 0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        int b;
        int ids[6] = '{0, 1, 2, 3, 5, 7};
        logic [W-1:0] pw;
        void'($urandom(32'h99def5b7));
        repeat (20) @(posedge clk);
        rstn <= 1;
        repeat (3) @(posedge clk);
        u_host.rd(8'h0B, d); `CHK("reset flag", 16'h0040, d)
        u_host.wr(8'h0A, 16'h0040); `CHK("reset irq", 1'b1, irq_n)
        u_host.rd(8'h0C, d); u_host.rd(8'h0B, d); `CHK("cleared", 16'h0000, d)
        foreach (ids[k]) begin
            b = ids[k] == 7 ? 1 : ids[k];
            ev(ids[k]); `CHK("masked irq", 1'b1, irq_n)
            u_host.wr(8'h0A, 16'h0001 << b); `CHK("irq low", 1'b0, irq_n)
            u_host.service(d); `CHK("status", 16'h0001 << b, d)
            `CHK("irq release", 1'b1, irq_n)
        end
        u_host.wr(8'h0A, 16'h0010);
        @(posedge clk) zero_cross_in <= 1;
        repeat (3) @(posedge clk);
        u_host.rd(8'h0C, d); `CHK("zc live", 16'h0010, d)
        `CHK("zc irq", 1'b0, irq_n)
        @(posedge clk) zero_cross_in <= 0;
        repeat (3) @(posedge clk);
        #1 `CHK("zc drop", 1'b1, irq_n)
        for (int k = 0; k < 8; k++) begin
            pw = W'($urandom);
            @(posedge clk) {mode_wr, mode_wdata, power_lowpass_output} <= {1'b1, 3'(k), pw};
            curr_sample <= W'($urandom);
            volt_sample <= W'($urandom);
            @(posedge clk) {mode_wr, wave_strobe} <= 2'b01;
            @(posedge clk) wave_strobe <= 0;
            #1 `CHK("mode", 3'(k), {positive_only_accumulate, waveform_source_select})
            `CHK("wave", k[1:0] == 3 ? volt_sample : k[1:0] == 2 ? curr_sample : k[1:0] == 0 ? pw : 24'h0, waveform_data)
            `CHK("accum", k[2] && pw[W-1] ? 24'h0 : pw, accum_power)
        end
        u_host.wr(8'h0B, 16'hFFFF);
        u_host.rd(8'h33, d); `CHK("unmapped", 16'h0000, d)
        @(posedge clk) sw_reset <= 1;
        @(posedge clk) sw_reset <= 0;
        repeat (2) @(posedge clk);
        u_host.rd(8'h0B, d); `CHK("soft reset flag", 16'h0040, d)
        u_host.rd(8'h0A, d); `CHK("soft reset enable", 16'h0000, d)
        `CHK("mode default", 1'b0, positive_only_accumulate)
        summarize();
    end
endmodule // tb_mif_irq_flags
